// >>> shared/pecl_params.svh
// Register offsets, field positions and reset values of the error counter and LED block.
`ifndef PECL_PARAMS_SVH
`define PECL_PARAMS_SVH
`define PECL_IDX_ADDR 8'h12
`define PECL_IDX_FCAR 8'h13
`define PECL_IDX_DISC 8'h14
`define PECL_IDX_EFRM 8'h15
`define PECL_IDX_SYM 8'h16
`define PECL_IDX_EEOF 8'h17
`define PECL_IDX_EOF10 8'h18
`define PECL_IDX_JAB 8'h19
`define PECL_IDX_CTRL 8'h1B
`define PECL_IDX_IRQ_STAT 8'h20
`define PECL_IDX_IRQ_EN 8'h21
`define PECL_IDX_IRQ_CLR 8'h22
`define PECL_ADDR_RESET 5'h01
`define PECL_CTRL_RESET 6'h00
`define PECL_CTRL_WMASK 6'h2F
`define PECL_BIT_JABDIS 3
`define PECL_BIT_PROBE 5
`define PECL_SYM_RUN 3'h6
`define PECL_NUM_CNT 7
`endif

// >>> shared/pecl_pkg.sv
// Types shared by the error counter and LED block.
package pecl_pkg;
    typedef enum logic [2:0] {
        PECL_LED_ACT_LINK = 3'b000,
        PECL_LED_SPD_COL = 3'b001,
        PECL_LED_SPD_LINK = 3'b010,
        PECL_LED_ACT_COL = 3'b011,
        PECL_LED_OFF_OFF = 3'b100,
        PECL_LED_OFF_ON = 3'b101,
        PECL_LED_ON_OFF = 3'b110,
        PECL_LED_ON_ON = 3'b111
    } pecl_led_mode_t;
endpackage

// >>> rtl/pecl_regs.sv
// Error event counters, LED mapping and jabber control behind an APB slave.
//
// Functional notes
// - Address register: low five bits, default 00001
// - False carrier counter, sixteen bits, clears on read
// - Disconnect counter saturates and clears on read
// - Error frame counter counts once per frame
// - Symbol error counter saturates, clears on read
// - Six consecutive bad symbols in a frame count as one; outside a frame each counts
// - Premature frame end counter saturates, clears on read
// - Slow end-of-frame error counter saturates, clears on read
// - Jabber detect counter saturates, clears on read
// - Three-bit field selects both LED sources
// - Probe mapping bit defaults zero, keep zero
// - Jabber control drops carrier sense at 100M
`timescale 1ns/1ps
`include "pecl_params.svh"

module pecl_regs #(
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [4:0] phy_addr_i,
    input wire logic false_carrier_i,
    input wire logic disconnect_i,
    input wire logic rx_frame_active_i,
    input wire logic rx_error_i,
    input wire logic symbol_error_i,
    input wire logic early_frame_end_i,
    input wire logic slow_eof_error_i,
    input wire logic jabber_detect_i,
    input wire logic act_i,
    input wire logic link_i,
    input wire logic speed_i,
    input wire logic collision_i,
    input wire logic rx_carrier_i,
    input wire logic jabber_mode_i,
    input wire logic probe_a_i,
    input wire logic probe_b_i,
    output logic activity_indicator_out_o,
    output logic link_indicator_out_o,
    output logic carrier_sense_o,
    output pecl_pkg::pecl_led_mode_t led_mode_o,
    output logic irq_o
);
    import pecl_pkg::*;

    localparam int NC = `PECL_NUM_CNT;

    if (CNT_W < 1 || CNT_W > 32) begin : g_chk_w
        $error("CNT_W must lie between 1 and 32.");
    end

    // Address index of each counter, in counter order.
    function automatic logic [7:0] cnt_idx(input int k);
        logic [7:0] base;
        base = `PECL_IDX_FCAR;
        return base + k[7:0];
    endfunction

    function automatic logic [7:0] word_idx(input logic [31:0] a);
        return a[9:2];
    endfunction

    logic [NC-1:0] ev_raw;
    assign ev_raw = {jabber_detect_i, slow_eof_error_i, early_frame_end_i, symbol_error_i,
                     rx_error_i, disconnect_i, false_carrier_i};

    // Every event pin comes from outside the clock domain and is synchronised.
    logic [NC+8:0] s1_q, s2_q;
    always_ff @(posedge core_clk_i) begin
        s1_q <= {probe_b_i, probe_a_i, jabber_mode_i, rx_carrier_i, collision_i, speed_i,
                 link_i, act_i, rx_frame_active_i, ev_raw};
        s2_q <= s1_q;
    end
    logic [NC-1:0] ev_s;
    logic frm_s, act_s, link_s, spd_s, col_s, crs_s, jmode_s, pra_s, prb_s;
    assign ev_s = s2_q[NC-1:0];
    assign {prb_s, pra_s, jmode_s, crs_s, col_s, spd_s, link_s, act_s, frm_s} = s2_q[NC+8:NC];

    logic [NC-1:0] ev_s_q;
    logic frm_q;
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ev_s_q <= '0;
            frm_q <= 1'b0;
        end else begin
            ev_s_q <= ev_s;
            frm_q <= frm_s;
        end
    end
    logic [NC-1:0] ev_rise;
    assign ev_rise = ev_s & ~ev_s_q;

    // Error frame: one count per frame that saw any receive error.
    logic frm_hit_q;
    logic frm_err_ev;
    // At the first cycle of a frame the hit flag still belongs to the last frame.
    assign frm_err_ev = ev_rise[2] & frm_s & (~frm_hit_q | ~frm_q);
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            frm_hit_q <= 1'b0;
        end else if (frm_s && !frm_q) begin
            frm_hit_q <= ev_rise[2];
        end else if (frm_err_ev) begin
            frm_hit_q <= 1'b1;
        end
    end

    // Symbol errors: a run counter gives one count per six consecutive bad symbols in a frame; outside a frame each counts.
    logic [2:0] run_q;
    logic sym_ev;
    assign sym_ev = ev_rise[3] && (run_q == 3'h0);
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || !frm_s) begin
            run_q <= 3'h0;
        end else if (ev_rise[3]) begin
            run_q <= (run_q == `PECL_SYM_RUN - 3'h1) ? 3'h0 : run_q + 3'h1;
        end
    end

    logic [NC-1:0] ev_cnt;
    assign ev_cnt = {ev_rise[6:4], sym_ev, frm_err_ev, ev_rise[1:0]};

    // APB decode.
    logic acc, rd_acc, wr_acc;
    logic [7:0] widx;
    assign acc = psel_i & penable_i;
    assign rd_acc = acc & ~pwrite_i;
    assign wr_acc = acc & pwrite_i & pstrb_i[0];
    assign widx = word_idx(paddr_i);
    assign pready_o = 1'b1;

    logic [CNT_W-1:0] cnt_q [NC];
    logic [NC-1:0] rd_hit;
    genvar g;
    for (g = 0; g < NC; g++) begin : g_cnt
        assign rd_hit[g] = rd_acc && (widx == cnt_idx(g));
        always_ff @(posedge core_clk_i) begin
            if (!resetn_i) begin
                cnt_q[g] <= '0;
            end else if (rd_hit[g]) begin
                cnt_q[g] <= {{(CNT_W-1){1'b0}}, ev_cnt[g]};
            end else if (ev_cnt[g] && !(&cnt_q[g])) begin
                cnt_q[g] <= cnt_q[g] + 1'b1;
            end
        end
        chk_count_saturates: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            (&cnt_q[g]) && !rd_hit[g] |=> (&cnt_q[g]))
            else $error("Counter left full scale without a read.");
        chk_read_clears: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            rd_hit[g] |=> cnt_q[g] == {{(CNT_W-1){1'b0}}, $past(ev_cnt[g])})
            else $error("Counter not cleared by read.");
        chk_count_step: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            ev_cnt[g] && !rd_hit[g] && !(&cnt_q[g]) |=> cnt_q[g] == $past(cnt_q[g]) + 1'b1)
            else $error("Counter missed an event.");
        chk_count_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
            !ev_cnt[g] && !rd_hit[g] |=> $stable(cnt_q[g]))
            else $error("Counter moved without an event.");
    end

    // Control register and interrupt registers.
    logic [5:0] ctrl_q;
    logic [NC-1:0] irq_stat_q, irq_en_q;
    logic wr_ctrl, wr_en, wr_clr;
    assign wr_ctrl = wr_acc && (widx == `PECL_IDX_CTRL);
    assign wr_en = wr_acc && (widx == `PECL_IDX_IRQ_EN);
    assign wr_clr = wr_acc && (widx == `PECL_IDX_IRQ_CLR);
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ctrl_q <= `PECL_CTRL_RESET;
            irq_en_q <= '0;
            irq_stat_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata_i[5:0] & `PECL_CTRL_WMASK;
            end
            if (wr_en) begin
                irq_en_q <= pwdata_i[NC-1:0];
            end
            // A new event wins over a clear in the same cycle.
            irq_stat_q <= (irq_stat_q & ~(wr_clr ? pwdata_i[NC-1:0] : '0)) | ev_cnt;
        end
    end
    assign irq_o = |(irq_stat_q & irq_en_q);

    // Read mux.
    logic [31:0] rd_val;
    logic known;
    always_comb begin
        rd_val = 32'h0000_0000;
        known = 1'b1;
        case (widx)
            `PECL_IDX_ADDR: rd_val = {27'h0, phy_addr_i};
            `PECL_IDX_CTRL: rd_val = {26'h0, ctrl_q};
            `PECL_IDX_IRQ_STAT: rd_val = {{(32-NC){1'b0}}, irq_stat_q};
            `PECL_IDX_IRQ_EN: rd_val = {{(32-NC){1'b0}}, irq_en_q};
            `PECL_IDX_IRQ_CLR: rd_val = 32'h0000_0000;
            default: begin
                known = 1'b0;
                for (int k = 0; k < NC; k++) begin
                    if (widx == cnt_idx(k)) begin
                        rd_val = 32'(cnt_q[k]);
                        known = 1'b1;
                    end
                end
            end
        endcase
    end
    assign pslverr_o = acc & ~known;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_val;
        end
    end

    // LED mapping and carrier sense.
    pecl_led_mode_t mode;
    logic act_src, link_src;
    assign mode = pecl_led_mode_t'(ctrl_q[2:0]);
    assign led_mode_o = mode;
    always_comb begin
        act_src = 1'b0;
        link_src = 1'b0;
        case (mode)
            PECL_LED_ACT_LINK: {act_src, link_src} = {act_s, link_s};
            PECL_LED_SPD_COL: {act_src, link_src} = {spd_s, col_s};
            PECL_LED_SPD_LINK: {act_src, link_src} = {spd_s, link_s};
            PECL_LED_ACT_COL: {act_src, link_src} = {act_s, col_s};
            PECL_LED_OFF_OFF: {act_src, link_src} = 2'b00;
            PECL_LED_OFF_ON: {act_src, link_src} = 2'b01;
            PECL_LED_ON_OFF: {act_src, link_src} = 2'b10;
            PECL_LED_ON_ON: {act_src, link_src} = 2'b11;
            default: {act_src, link_src} = 2'b00;
        endcase
        if (ctrl_q[`PECL_BIT_PROBE]) begin
            {act_src, link_src} = {pra_s, prb_s};
        end
    end

    // LED pins are active low: on drives the pin low.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            activity_indicator_out_o <= 1'b1;
            link_indicator_out_o <= 1'b1;
            carrier_sense_o <= 1'b0;
        end else begin
            activity_indicator_out_o <= ~act_src;
            link_indicator_out_o <= ~link_src;
            carrier_sense_o <= crs_s & ~(ctrl_q[`PECL_BIT_JABDIS] & jmode_s & spd_s);
        end
    end

    chk_jabber_crs_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q[`PECL_BIT_JABDIS] && jmode_s && spd_s && $stable(ctrl_q) |=> !carrier_sense_o)
        else $error("Carrier sense not cut in jabber.");
    chk_led_force_on: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q == 6'h07 |=> !activity_indicator_out_o && !link_indicator_out_o)
        else $error("LEDs not both on in mode 111.");
    chk_led_force_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q == 6'h04 |=> activity_indicator_out_o && link_indicator_out_o)
        else $error("LEDs not both off in mode 100.");
    chk_addr_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        psel_i && !penable_i && !pwrite_i && widx == `PECL_IDX_ADDR
        |=> prdata_o[31:5] == 27'h0)
        else $error("Address register upper bits not zero.");
    chk_symbol_run: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ev_rise[3] && run_q != 3'h0 |-> !ev_cnt[3])
        else $error("Symbol counted inside a run of six.");
    chk_frame_once: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        frm_hit_q && frm_s && frm_q |-> !ev_cnt[2])
        else $error("Error frame counted twice.");
    chk_probe_default: assert property (@(posedge core_clk_i)
        !resetn_i |=> ctrl_q[`PECL_BIT_PROBE] == 1'b0)
        else $error("Probe bit not zero after reset.");

    // Register bus steps that the checks below are built from.
    sequence s_read_setup(logic [7:0] idx);
        psel_i && !penable_i && !pwrite_i && widx == idx;
    endsequence

    sequence s_access;
        psel_i && penable_i;
    endsequence

    sequence s_write(logic [7:0] idx);
        psel_i && penable_i && pwrite_i && pstrb_i[0] && widx == idx;
    endsequence

    // Read data is latched in the setup cycle and must stand through the access cycle.
    chk_addr_value: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_read_setup(`PECL_IDX_ADDR) |=> prdata_o[4:0] == $past(phy_addr_i))
        else $error("Address register does not show the strap value.");
    chk_ctrl_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_read_setup(`PECL_IDX_CTRL) ##1 s_access |-> prdata_o == {26'h0, ctrl_q})
        else $error("Control read data wrong in access cycle.");
    chk_unmapped_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        psel_i && !penable_i && !pwrite_i && !known |=> prdata_o == 32'h0000_0000)
        else $error("Unmapped read returned data.");

    // Writes land only in the access cycle and only the writable bits take them.
    chk_ctrl_write: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_write(`PECL_IDX_CTRL) |=> ctrl_q == ($past(pwdata_i[5:0]) & `PECL_CTRL_WMASK))
        else $error("Control write did not land.");
    chk_write_strobe: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        psel_i && penable_i && pwrite_i && !pstrb_i[0] && widx == `PECL_IDX_CTRL
        |=> $stable(ctrl_q))
        else $error("Control changed by a write without strobe.");
    chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q[4] == 1'b0)
        else $error("Reserved control bit set.");
    chk_irq_enable: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_write(`PECL_IDX_IRQ_EN) |=> irq_en_q == $past(pwdata_i[NC-1:0]))
        else $error("Interrupt enable write did not land.");

    // A counted event must set its status bit even when a clear arrives with it.
    chk_irq_set_wins: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        |ev_cnt |=> (irq_stat_q & $past(ev_cnt)) == $past(ev_cnt))
        else $error("Event lost against a status clear.");
    chk_irq_clears: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_write(`PECL_IDX_IRQ_CLR) |=> (irq_stat_q & $past(pwdata_i[NC-1:0] & ~ev_cnt)) == '0)
        else $error("Status bit survived its clear.");

    // Carrier sense passes through unless the jabber cut applies at 100M.
    chk_crs_pass: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !ctrl_q[`PECL_BIT_JABDIS] && $stable(ctrl_q) |=> carrier_sense_o == $past(crs_s))
        else $error("Carrier sense cut without jabber control.");
    chk_crs_slow: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q[`PECL_BIT_JABDIS] && !spd_s && $stable(ctrl_q)
        |=> carrier_sense_o == $past(crs_s))
        else $error("Carrier sense cut at 10M.");

    // LED pins follow their selected sources one cycle later, active low.
    chk_led_follow: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        mode == PECL_LED_ACT_LINK && !ctrl_q[`PECL_BIT_PROBE]
        |=> activity_indicator_out_o == !$past(act_s) && link_indicator_out_o == !$past(link_s))
        else $error("LEDs do not follow activity and link.");
    chk_probe_route: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q[`PECL_BIT_PROBE]
        |=> activity_indicator_out_o == !$past(pra_s) && link_indicator_out_o == !$past(prb_s))
        else $error("Probe mapping not on the LEDs.");

    // The first error of a frame and the first bad symbol of a run must count.
    chk_frame_first: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        frm_s && frm_q && !frm_hit_q && ev_rise[2] |-> ev_cnt[2])
        else $error("First error of a frame not counted.");
    chk_frame_start: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        frm_s && !frm_q && ev_rise[2] |-> ev_cnt[2])
        else $error("Error at frame start not counted.");
    chk_symbol_first: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ev_rise[3] && run_q == 3'h0 |-> ev_cnt[3])
        else $error("First bad symbol of a run not counted.");

    // Outputs must be quiet right after reset.
    chk_reset_quiet: assert property (@(posedge core_clk_i)
        !resetn_i |=> prdata_o == 32'h0000_0000 && !irq_o && activity_indicator_out_o
        && link_indicator_out_o && !carrier_sense_o)
        else $error("Outputs not quiet after reset.");
endmodule // pecl_regs

// >>> testbench/pecl_partner.sv
// Event source model standing in for the receive, line code and jabber logic.
`timescale 1ns/1ps
module pecl_partner (
    input wire logic clk_i,
    output logic [6:0] ev_o
);
    initial begin
        ev_o = 7'h00;
    end
    // Each rising edge is one event, so every level is held long enough to pass a synchroniser.
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(posedge clk_i) ev_o[ch] <= 1'b1;
            repeat (2) @(posedge clk_i);
            ev_o[ch] <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule // pecl_partner

// >>> testbench/test_phy_error_counters_led_control.sv
// Self-checking bench for the error counter, LED and jabber register block.
`timescale 1ns/1ps
`include "pecl_params.svh"
module test_phy_error_counters_led_control;
    import pecl_pkg::*;
    localparam int CW = 4;
    localparam int SAT = 2 ** CW - 1;
    logic core_clk_i = 0, resetn_i = 0, psel = 0, pen = 0, pwr = 0, pready, err, pslverr;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [4:0] phy_addr = 5'h01;
    logic frame = 0, act = 0, link = 0, spd = 0, col = 0, jmode = 0, pa = 0, pb = 0, crs = 1;
    logic act_n, link_n, cs, irq, a_on, l_on;
    logic [6:0] ev;
    pecl_led_mode_t mode;
    int error_cnt = 0, checks = 0, exp, n;

    pecl_regs #(.CNT_W(CW)) u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .phy_addr_i(phy_addr),
        .false_carrier_i(ev[0]), .disconnect_i(ev[1]), .rx_frame_active_i(frame),
        .rx_error_i(ev[2]), .symbol_error_i(ev[3]), .early_frame_end_i(ev[4]),
        .slow_eof_error_i(ev[5]), .jabber_detect_i(ev[6]), .act_i(act), .link_i(link),
        .speed_i(spd), .collision_i(col), .rx_carrier_i(crs), .jabber_mode_i(jmode),
        .probe_a_i(pa), .probe_b_i(pb), .activity_indicator_out_o(act_n),
        .link_indicator_out_o(link_n), .carrier_sense_o(cs), .led_mode_o(mode), .irq_o(irq));
    pecl_partner u_partner (.clk_i(core_clk_i), .ev_o(ev));

    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; read data and error are taken in the access cycle that pready ends.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int i;
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk_i);
        pen <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk_i);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    initial begin
        void'($urandom(95));
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        phy_addr <= 5'($urandom);
        pa <= 1'($urandom);
        pb <= 1'($urandom);
        apb(1'b1, `PECL_IDX_ADDR, 32'hFFFF);
        apb(1'b0, `PECL_IDX_ADDR, 32'h0);
        check(rd, {27'h0, phy_addr});
        apb(1'b0, `PECL_IDX_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, `PECL_IDX_CTRL, 32'hFFFF);
        apb(1'b0, `PECL_IDX_CTRL, 32'h0);
        check(rd, 32'h2F);
        $display("reset and access test done");
        for (int ch = 0; ch < 7; ch++) begin
            apb(1'b0, `PECL_IDX_FCAR + 8'(ch), 32'h0);
            check(rd, 32'h0);
            n = (ch == 3) ? 12 + $urandom_range(0, 6) : (ch == 0 ? 20 : $urandom_range(1, 20));
            @(posedge core_clk_i) frame <= 1'b1;
            u_partner.pulse(ch, n);
            repeat (6) @(posedge core_clk_i);
            frame <= 1'b0;
            exp = (ch == 2) ? 1 : (ch == 3 ? 1 + (n - 1) / 6 : n);
            apb(1'b0, `PECL_IDX_FCAR + 8'(ch), 32'h0);
            check(rd, (exp > SAT) ? SAT : exp);
            apb(1'b0, `PECL_IDX_FCAR + 8'(ch), 32'h0);
            check(rd, 32'h0);
        end
        $display("counter test done");
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `PECL_IDX_CTRL, 32'(m));
            @(posedge core_clk_i) {act, link, spd, col} <= 4'($urandom);
            repeat (5) @(posedge core_clk_i);
            a_on = (m < 4) ? ((m == 1 || m == 2) ? spd : act) : m[1];
            l_on = (m < 4) ? (m[0] ? col : link) : m[0];
            check({mode, act_n, link_n}, {m[2:0], ~a_on, ~l_on});
        end
        spd <= 1'b1;
        jmode <= 1'b1;
        apb(1'b1, `PECL_IDX_CTRL, 32'h8);
        repeat (5) @(posedge core_clk_i);
        check(cs, 1'b0);
        apb(1'b1, `PECL_IDX_CTRL, 32'h0);
        repeat (5) @(posedge core_clk_i);
        check(cs, 1'b1);
        crs <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        check(cs, 1'b0);
        $display("led and jabber test done");
        apb(1'b1, `PECL_IDX_IRQ_EN, 32'h7F);
        apb(1'b1, `PECL_IDX_IRQ_CLR, 32'h7F);
        @(posedge core_clk_i);
        check(irq, 1'b0);
        u_partner.pulse(6, 1);
        repeat (6) @(posedge core_clk_i);
        check(irq, 1'b1);
        apb(1'b0, `PECL_IDX_IRQ_STAT, 32'h0);
        check(rd, 32'h40);
        apb(1'b1, `PECL_IDX_IRQ_EN, 32'h0);
        @(posedge core_clk_i);
        check(irq, 1'b0);
        apb(1'b0, 8'h30, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("interrupt and unmapped test done");
        final_report();
    end
endmodule // test_phy_error_counters_led_control
